// *** rtl/cfd_clock_detect.sv ***
// Summary of operation
// - both reference frequencies are set either by a host selection command or by automatic detection.
// - detection classifies the main reference as 13, 26, 19.2 or 38.4 MHz.
// - detection classifies the slow reference as 3.2, 16.384, 32 or 32.768 kHz.
// - in any low-power mode the baseband timebase follows the slow reference, not the main one.
// - one main reference input is used, accepted as a sine wave or a square wave.
// - the clock-shape strap high means square wave, low means sine wave.
`include "cfd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cfd_clock_detect
    import cfd_pkg::*;
#(
    parameter int MAIN_WINDOW = `CFD_MAIN_WINDOW
)
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // reference clock pins and strap
    input  wire logic main_reference_clock_input,
    input  wire logic slow_reference_clock_input,
    input  wire logic clock_shape_strap,
    // host selection command
    input  wire logic host_sel_valid,
    input  wire logic [1:0] host_main_sel,
    input  wire logic [1:0] host_slow_sel,
    output logic      host_sel_ready,
    // automatic detection
    input  wire logic auto_detect_start,
    output logic      detect_busy,
    output logic      detect_done,
    output logic      detect_fail,
    // selection result
    output logic [1:0] main_freq_sel,
    output logic [1:0] slow_freq_sel,
    output logic      reference_is_square,
    // baseband timebase
    input  wire logic low_power_mode,
    output logic      timing_from_slow,
    output logic      baseband_tick
);

    localparam int MW = `CFD_MAIN_CNT_W;
    localparam int SW = `CFD_SLOW_CNT_W;
    localparam longint MAIN_KHZ [4] = '{`CFD_MAIN_KHZ_0, `CFD_MAIN_KHZ_1,
                                        `CFD_MAIN_KHZ_2, `CFD_MAIN_KHZ_3};
    localparam longint SLOW_MHZ [4] = '{`CFD_SLOW_MHZ_0, `CFD_SLOW_MHZ_1,
                                        `CFD_SLOW_MHZ_2, `CFD_SLOW_MHZ_3};

    // the window must hold the highest edge count and still resolve the lowest
    if (MAIN_WINDOW < 1024 || MAIN_WINDOW > 65535)
    begin : g_bad_window
        $error("cfd_clock_detect: MAIN_WINDOW out of range");
    end

    // ------------------------------------------------------------------------
    // pin synchronisers and strap capture
    // ------------------------------------------------------------------------
    logic [1:0] strap_age_q, strap_age_d;
    logic square_q, square_d;
    logic main_rise, slow_rise;

    cfd_edge_sync u_main_sync
    (
        .mclk      (mclk),
        .reset     (reset),
        .pin_in    (main_reference_clock_input),
        .filter_en (~square_q),
        .level     (),
        .rise      (main_rise)
    );

    cfd_edge_sync u_slow_sync
    (
        .mclk      (mclk),
        .reset     (reset),
        .pin_in    (slow_reference_clock_input),
        .filter_en (1'b0),
        .level     (),
        .rise      (slow_rise)
    );

    logic strap_s1_q, strap_s2_q;

    always_comb
    begin
        strap_age_d = (strap_age_q == 2'h3) ? strap_age_q : strap_age_q + 2'h1;
        // strap is caught once, only after the synchroniser holds its real level
        square_d    = (strap_age_q == 2'h3) ? square_q : strap_s2_q;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            strap_s1_q    <= 1'b0;
            strap_s2_q    <= 1'b0;
            strap_age_q   <= 2'h0;
            square_q      <= 1'b0;
        end
        else
        begin
            strap_s1_q    <= clock_shape_strap;
            strap_s2_q    <= strap_s1_q;
            strap_age_q   <= strap_age_d;
            square_q      <= square_d;
        end
    end

    // ------------------------------------------------------------------------
    // frequency classification
    // ------------------------------------------------------------------------
    logic [MW-1:0] edge_cnt_q, edge_cnt_d;
    logic [SW-1:0] slow_cnt_q, slow_cnt_d;
    logic [3:0]    main_hit, slow_hit;

    for (genvar i = 0; i < 4; i++)
    begin : g_cls
        localparam longint MEXP = (longint'(MAIN_WINDOW) * MAIN_KHZ[i] * 1000)
                                  / `CFD_MCLK_HZ;
        localparam longint MTOL = MEXP / `CFD_MAIN_TOL_DIV;
        localparam longint SEXP = (longint'(`CFD_MCLK_HZ) * 1000) / SLOW_MHZ[i];
        localparam longint STOL = SEXP / `CFD_SLOW_TOL_DIV;
        assign main_hit[i] = (edge_cnt_q >= MW'(MEXP - MTOL))
                          && (edge_cnt_q <= MW'(MEXP + MTOL));
        assign slow_hit[i] = (slow_cnt_q >= SW'(SEXP - STOL))
                          && (slow_cnt_q <= SW'(SEXP + STOL));
    end

    logic [1:0] main_code, slow_code;
    logic       main_ok, slow_ok;

    always_comb
    begin
        main_code = 2'h0;
        slow_code = 2'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (main_hit[i])
                main_code = 2'(i);
            if (slow_hit[i])
                slow_code = 2'(i);
        end
        main_ok = $onehot(main_hit);
        slow_ok = $onehot(slow_hit);
    end

    // ------------------------------------------------------------------------
    // selection sequencer
    // ------------------------------------------------------------------------
    localparam int WW = $clog2(MAIN_WINDOW + 1);

    cfd_state_e    state_q, state_d;
    logic [WW-1:0] win_cnt_q, win_cnt_d;
    cfd_sel_t      main_sel_q, main_sel_d, slow_sel_q, slow_sel_d;
    logic          done_q, done_d, fail_q, fail_d;

    always_comb
    begin
        state_d    = state_q;
        win_cnt_d  = win_cnt_q;
        edge_cnt_d = edge_cnt_q;
        slow_cnt_d = slow_cnt_q;
        main_sel_d = main_sel_q;
        slow_sel_d = slow_sel_q;
        done_d     = 1'b0;
        fail_d     = fail_q;
        case (state_q)
            CFD_ST_IDLE:
            begin
                if (host_sel_valid)
                begin
                    main_sel_d = host_main_sel;
                    slow_sel_d = host_slow_sel;
                    fail_d     = 1'b0;
                end
                else if (auto_detect_start)
                begin
                    state_d    = CFD_ST_MAIN;
                    win_cnt_d  = '0;
                    edge_cnt_d = '0;
                    fail_d     = 1'b0;
                end
            end
            CFD_ST_MAIN:
            begin
                win_cnt_d = win_cnt_q + 1'b1;
                if (main_rise)
                    edge_cnt_d = edge_cnt_q + 1'b1;
                if (win_cnt_q == WW'(MAIN_WINDOW - 1))
                    state_d = CFD_ST_SLOW_SYNC;
            end
            CFD_ST_SLOW_SYNC:
            begin
                // no timeout: the slow reference never stops
                slow_cnt_d = '0;
                if (slow_rise)
                    state_d = CFD_ST_SLOW;
            end
            CFD_ST_SLOW:
            begin
                // saturate so a stray long period cannot wrap into a match
                if (slow_cnt_q != '1)
                    slow_cnt_d = slow_cnt_q + 1'b1;
                if (slow_rise)
                    state_d = CFD_ST_DECIDE;
            end
            CFD_ST_DECIDE:
            begin
                state_d = CFD_ST_IDLE;
                done_d  = 1'b1;
                if (main_ok && slow_ok)
                begin
                    main_sel_d = main_code;
                    slow_sel_d = slow_code;
                end
                else
                    fail_d = 1'b1;
            end
            default:
                state_d = CFD_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_q    <= CFD_ST_IDLE;
            win_cnt_q  <= '0;
            edge_cnt_q <= '0;
            slow_cnt_q <= '0;
            main_sel_q <= `CFD_RST_MAIN_SEL;
            slow_sel_q <= `CFD_RST_SLOW_SEL;
            done_q     <= 1'b0;
            fail_q     <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            win_cnt_q  <= win_cnt_d;
            edge_cnt_q <= edge_cnt_d;
            slow_cnt_q <= slow_cnt_d;
            main_sel_q <= main_sel_d;
            slow_sel_q <= slow_sel_d;
            done_q     <= done_d;
            fail_q     <= fail_d;
        end
    end

    // ------------------------------------------------------------------------
    // baseband timebase
    // ------------------------------------------------------------------------
    logic slow_src_q, slow_src_d, tick_q, tick_d;

    always_comb
    begin
        slow_src_d = low_power_mode;
        tick_d     = slow_src_q ? slow_rise : main_rise;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            slow_src_q <= 1'b0;
            tick_q     <= 1'b0;
        end
        else
        begin
            slow_src_q <= slow_src_d;
            tick_q     <= tick_d;
        end
    end

    assign host_sel_ready      = (state_q == CFD_ST_IDLE);
    assign detect_busy         = (state_q != CFD_ST_IDLE);
    assign detect_done         = done_q;
    assign detect_fail         = fail_q;
    assign main_freq_sel       = main_sel_q;
    assign slow_freq_sel       = slow_sel_q;
    assign reference_is_square = square_q;
    assign timing_from_slow    = slow_src_q;
    assign baseband_tick       = tick_q;

endmodule // cfd_clock_detect

`default_nettype wire

// *** rtl/cfd_defines.svh ***
`ifndef CFD_DEFINES_SVH
`define CFD_DEFINES_SVH

// ----------------------------------------------------------------------------
// clock rate of mclk
// ----------------------------------------------------------------------------
`define CFD_MCLK_PERIOD_NS  8
`define CFD_MCLK_HZ         (1000000000 / `CFD_MCLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// supported main reference frequencies, in kHz, in selection-code order
// ----------------------------------------------------------------------------
`define CFD_MAIN_KHZ_0      13000
`define CFD_MAIN_KHZ_1      26000
`define CFD_MAIN_KHZ_2      19200
`define CFD_MAIN_KHZ_3      38400

// ----------------------------------------------------------------------------
// supported slow reference frequencies, in mHz, in selection-code order
// ----------------------------------------------------------------------------
`define CFD_SLOW_MHZ_0      3200000
`define CFD_SLOW_MHZ_1      16384000
`define CFD_SLOW_MHZ_2      32000000
`define CFD_SLOW_MHZ_3      32768000

// ----------------------------------------------------------------------------
// measurement window and match tolerances (1/div of the expected count)
// ----------------------------------------------------------------------------
`define CFD_MAIN_WINDOW     16384
`define CFD_MAIN_TOL_DIV    50
`define CFD_SLOW_TOL_DIV    100
`define CFD_MAIN_CNT_W      16
`define CFD_SLOW_CNT_W      17

// ----------------------------------------------------------------------------
// selection after reset
// ----------------------------------------------------------------------------
`define CFD_RST_MAIN_SEL    2'h0
`define CFD_RST_SLOW_SEL    2'h3

`endif

// *** rtl/cfd_pkg.sv ***
`default_nettype none

package cfd_pkg;

    typedef enum logic [2:0] {
        CFD_ST_IDLE,
        CFD_ST_MAIN,
        CFD_ST_SLOW_SYNC,
        CFD_ST_SLOW,
        CFD_ST_DECIDE
    } cfd_state_e;

    typedef logic [1:0] cfd_sel_t;

endpackage

`default_nettype wire

// *** rtl/cfd_edge_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module cfd_edge_sync
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // pin side
    input  wire logic pin_in,
    input  wire logic filter_en,
    // logic side
    output logic      level,
    output logic      rise
);

    logic s1_q, s2_q, s3_q, s4_q;
    logic filt_d, filt_q;
    logic rise_d, rise_q;

    // ------------------------------------------------------------------------
    // two-flop synchroniser, then an optional majority filter
    // ------------------------------------------------------------------------
    always_comb
    begin
        // a squared-up sine has slow edges and may chatter near threshold
        if (filter_en)
            filt_d = (s2_q & s3_q) | (s2_q & s4_q) | (s3_q & s4_q);
        else
            filt_d = s2_q;
        rise_d = filt_d & ~filt_q;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            s3_q   <= 1'b0;
            s4_q   <= 1'b0;
            filt_q <= 1'b0;
            rise_q <= 1'b0;
        end
        else
        begin
            s1_q   <= pin_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            s4_q   <= s3_q;
            filt_q <= filt_d;
            rise_q <= rise_d;
        end
    end

    assign level = filt_q;
    assign rise  = rise_q;

endmodule // cfd_edge_sync

`default_nettype wire

// *** tb/cfd_clock_detect_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module cfd_clock_detect_checker
(
    // clock and reset
    input wire logic       mclk,
    input wire logic       reset,
    // reference pins and strap
    input wire logic       main_reference_clock_input,
    input wire logic       slow_reference_clock_input,
    input wire logic       clock_shape_strap,
    // host selection
    input wire logic       host_sel_valid,
    input wire logic [1:0] host_main_sel,
    input wire logic [1:0] host_slow_sel,
    input wire logic       host_sel_ready,
    // detection
    input wire logic       auto_detect_start,
    input wire logic       detect_busy,
    input wire logic       detect_done,
    input wire logic       detect_fail,
    // result and timebase
    input wire logic [1:0] main_freq_sel,
    input wire logic [1:0] slow_freq_sel,
    input wire logic       reference_is_square,
    input wire logic       low_power_mode,
    input wire logic       timing_from_slow,
    input wire logic       baseband_tick
);
    // ------------------------------------------------------------------
    // edges since reset, saturating: the strap capture needs three
    // ------------------------------------------------------------------
    logic [2:0] age_q;
    logic [2:0] age_d;

    always_comb
    begin
        age_d = age_q;
        if (age_q != 3'h5)
            age_d = age_q + 3'h1;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            age_q <= 3'h0;
        else
            age_q <= age_d;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_host_apply: assert property (host_sel_valid && host_sel_ready |=>
        main_freq_sel == $past(host_main_sel) && slow_freq_sel == $past(host_slow_sel)
        && !detect_fail) else $error("host selection not applied");
    a_ready_idle: assert property (host_sel_ready != detect_busy)
        else $error("ready and busy disagree");
    a_start_busy: assert property (
        auto_detect_start && host_sel_ready && !host_sel_valid |=> detect_busy)
        else $error("start not taken");
    a_end_done: assert property ($fell(detect_busy) |-> detect_done)
        else $error("detection ended without done");
    a_sel_cause: assert property (
        $changed(main_freq_sel) || $changed(slow_freq_sel)
        |-> $past(host_sel_valid && host_sel_ready) || detect_done)
        else $error("selection changed without cause");
    a_fail_keep: assert property (
        detect_done && detect_fail |-> $stable(main_freq_sel) && $stable(slow_freq_sel))
        else $error("failed detection altered selection");
    a_lp_timebase: assert property (
        !$past(reset) |-> timing_from_slow == $past(low_power_mode))
        else $error("timebase source wrong");
    a_strap_hold: assert property (age_q == 3'h5 |-> $stable(reference_is_square))
        else $error("shape flag moved");

    c_ok: cover property (detect_done && !detect_fail);
    c_fail: cover property (detect_done && detect_fail);
    c_slow_tick: cover property (timing_from_slow && baseband_tick);
endmodule // cfd_clock_detect_checker

bind cfd_clock_detect cfd_clock_detect_checker u_chk (
    .mclk(mclk), .reset(reset), .main_reference_clock_input(main_reference_clock_input),
    .slow_reference_clock_input(slow_reference_clock_input),
    .clock_shape_strap(clock_shape_strap), .host_sel_valid(host_sel_valid),
    .host_main_sel(host_main_sel), .host_slow_sel(host_slow_sel),
    .host_sel_ready(host_sel_ready), .auto_detect_start(auto_detect_start),
    .detect_busy(detect_busy), .detect_done(detect_done), .detect_fail(detect_fail),
    .main_freq_sel(main_freq_sel), .slow_freq_sel(slow_freq_sel),
    .reference_is_square(reference_is_square), .low_power_mode(low_power_mode),
    .timing_from_slow(timing_from_slow), .baseband_tick(baseband_tick)
);

`default_nettype wire

// *** tb/cfd_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cfd_osc_model
(
    // half periods in ps
    input var int  main_half_ps,
    input var int  slow_half_ps,
    // oscillator pins
    output logic   main_clk,
    output logic   slow_clk
);
    // a zero half period before the bench settles would spin at time zero
    initial
    begin
        main_clk = 1'b0;
        forever #((main_half_ps > 0 ? main_half_ps : 1000) / 1000.0) main_clk = ~main_clk;
    end

    // slow source never pauses, frames or not
    initial
    begin
        slow_clk = 1'b0;
        forever #((slow_half_ps > 0 ? slow_half_ps : 1000) / 1000.0) slow_clk = ~slow_clk;
    end
endmodule // cfd_osc_model

`default_nettype wire

// *** tb/clock_frequency_detection_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cfd_defines.svh"

module clock_frequency_detection_tb;
    logic       mclk;
    logic       reset = 1'b1;
    logic       strap = 1'b1;
    logic       hv = 1'b0;
    logic [1:0] hm = 2'h0;
    logic [1:0] hs = 2'h0;
    logic       start = 1'b0;
    logic       lpm = 1'b0;
    logic       main_ref, slow_ref, ready, busy, done, fail, sq, tfs, tick;
    logic [1:0] msel, ssel, m, s;
    int         main_half = 38461;
    int         slow_half = 15625000;
    int         num_errors = 0;
    int         compares = 0;
    int         n;
    int         main_khz [4] = '{`CFD_MAIN_KHZ_0, `CFD_MAIN_KHZ_1, `CFD_MAIN_KHZ_2,
                                 `CFD_MAIN_KHZ_3};
    real        slow_mhz [4] = '{`CFD_SLOW_MHZ_0, `CFD_SLOW_MHZ_1, `CFD_SLOW_MHZ_2,
                                 `CFD_SLOW_MHZ_3};
    logic [1:0] slow_pick [4] = '{2'h2, 2'h3, 2'h1, 2'h2};

    cfd_osc_model osc (.main_half_ps(main_half), .slow_half_ps(slow_half),
        .main_clk(main_ref), .slow_clk(slow_ref));

    // short window keeps the main count of each detection near 1k cycles
    cfd_clock_detect #(.MAIN_WINDOW(1024)) DUT (.mclk(mclk), .reset(reset),
        .main_reference_clock_input(main_ref), .slow_reference_clock_input(slow_ref),
        .clock_shape_strap(strap), .host_sel_valid(hv), .host_main_sel(hm),
        .host_slow_sel(hs), .host_sel_ready(ready), .auto_detect_start(start),
        .detect_busy(busy), .detect_done(done), .detect_fail(fail),
        .main_freq_sel(msel), .slow_freq_sel(ssel), .reference_is_square(sq),
        .low_power_mode(lpm), .timing_from_slow(tfs), .baseband_tick(tick));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic host(input logic [1:0] a, input logic [1:0] b);
        @(posedge mclk);
        hv <= 1'b1;
        hm <= a;
        hs <= b;
        lpm <= 1'($urandom);
        @(posedge mclk);
        hv <= 1'b0;
    endtask

    task automatic count_ticks(input int cyc);
        repeat (8) @(posedge mclk);
        n = 0;
        repeat (cyc)
        begin
            @(posedge mclk);
            #1;
            n += int'(tick === 1'b1);
        end
    endtask

    // slow source needs an old half period to flush before a new measure
    task automatic detect(input int khz, input logic [1:0] sc, input logic [1:0] em,
                          input logic [1:0] es, input logic f);
        int k;
        main_half = 500000000 / khz;
        slow_half = int'(5.0e14 / slow_mhz[sc]);
        repeat (4000) @(posedge mclk);
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        repeat (20) @(posedge mclk);
        #1;
        chk("busy", 2'h1, {1'b0, busy});
        host(~em, ~es);
        k = 0;
        while (done !== 1'b1 && k < 40000)
        begin
            @(posedge mclk);
            #1;
            k++;
        end
        chk("done", 2'h1, {1'b0, done});
        chk("fail", {1'b0, f}, {1'b0, fail});
        chk("main sel", em, msel);
        chk("slow sel", es, ssel);
    endtask

    initial
    begin
        repeat (95000) @(posedge mclk);
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'h57954ee7));
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        chk("main sel", 2'h0, msel);
        chk("slow sel", 2'h3, ssel);
        chk("ready", 2'h1, {1'b0, ready});
        chk("shape", {1'b0, strap}, {1'b0, sq});
        $display("test reset done");
        repeat (8)
        begin
            m = 2'($urandom);
            s = 2'($urandom);
            host(m, s);
            #1;
            chk("main sel", m, msel);
            chk("slow sel", s, ssel);
        end
        $display("test host done");
        @(posedge mclk);
        lpm <= 1'b1;
        count_ticks(7813);
        chk("slow ticks", 2'h1, {1'b0, n >= 2 && n <= 3});
        chk("timing source", 2'h1, {1'b0, tfs});
        @(posedge mclk);
        lpm <= 1'b0;
        count_ticks(1024);
        chk("main ticks", 2'h1, {1'b0, n >= 104 && n <= 109});
        chk("timing source", 2'h0, {1'b0, tfs});
        $display("test timebase done");
        for (int i = 0; i < 4; i++)
            detect(main_khz[i], slow_pick[i], 2'(i), slow_pick[i], 1'b0);
        detect(8000, 2'h2, 2'h3, 2'h2, 1'b1);
        $display("test detect done");
        // second reset in mid-run, strap now low: sine input path with its filter
        @(posedge mclk);
        reset <= 1'b1;
        strap <= 1'b0;
        lpm <= 1'b0;
        main_half = 500000000 / `CFD_MAIN_KHZ_0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        chk("main sel", 2'h0, msel);
        chk("slow sel", 2'h3, ssel);
        chk("shape", {1'b0, strap}, {1'b0, sq});
        count_ticks(1024);
        chk("sine ticks", 2'h1, {1'b0, n >= 104 && n <= 109});
        $display("test sine done");
        report_and_stop();
    end
endmodule // clock_frequency_detection_tb

`default_nettype wire
